//--- bus_unit_pkg.sv
// Constants, codes and helper functions shared by the bus unit.
// Assumes a single 10 MHz clock and no software-visible registers.
package bus_unit_pkg;

  localparam int CLOCK_HZ = 10_000_000;
  localparam int QUEUE_DEPTH = 6;
  localparam int RESET_SEQ_CYCLES = 10;
  localparam logic [1:0] RG_ECHO_IGNORE = 2'h3;

  localparam logic [15:0] RESET_CODE_SEG = 16'hffff;
  localparam logic [15:0] RESET_IP = 16'h0000;

  // Bus cycle status codes, most significant bit first.
  localparam logic [2:0] ST_IRQ_ACK_STROBE_N = 3'h0;
  localparam logic [2:0] ST_IO_RD = 3'h1;
  localparam logic [2:0] ST_IO_WR = 3'h2;
  localparam logic [2:0] ST_HALT = 3'h3;
  localparam logic [2:0] ST_FETCH = 3'h4;
  localparam logic [2:0] ST_MEM_RD = 3'h5;
  localparam logic [2:0] ST_MEM_WR = 3'h6;
  localparam logic [2:0] ST_PASSIVE = 3'h7;

  // Instruction queue status codes, high bit first.
  localparam logic [1:0] QS_NOP = 2'h0;
  localparam logic [1:0] QS_FIRST = 2'h1;
  localparam logic [1:0] QS_EMPTY = 2'h2;
  localparam logic [1:0] QS_NEXT = 2'h3;

  // Segment codes as shown on the upper status lines.
  localparam logic [1:0] SEG_EXTRA = 2'h0;
  localparam logic [1:0] SEG_STACK = 2'h1;
  localparam logic [1:0] SEG_CODE = 2'h2;
  localparam logic [1:0] SEG_DATA = 2'h3;

  typedef enum logic [2:0] {
    BS_IDLE = 3'b000,
    BS_T1 = 3'b001,
    BS_T2 = 3'b011,
    BS_T3 = 3'b010,
    BS_T4 = 3'b110,
    BS_TW = 3'b111,
    BS_HOLD = 3'b100
  } bus_state_t;

  function automatic logic [19:0] phys_addr(input logic [15:0] seg, input logic [15:0] off);
    phys_addr = {seg, 4'h0} + {4'h0, off};
  endfunction : phys_addr

  function automatic logic is_read(input logic [2:0] kind);
    is_read = (kind == ST_IO_RD) || (kind == ST_MEM_RD) || (kind == ST_FETCH);
  endfunction : is_read

  function automatic logic is_write(input logic [2:0] kind);
    is_write = (kind == ST_IO_WR) || (kind == ST_MEM_WR);
  endfunction : is_write

endpackage : bus_unit_pkg

//--- bus_unit.sv
// Bus interface unit: prefetch queue, bus cycle sequencer, strobes,
// status codes and bus arbitration for both system modes.
// Assumes the execution unit runs on clock_i; all pins are synchronised.
//
// What this block does
// R1 - Maximum mode drives three-bit bus cycle status
// R2 - Hold acknowledge floats status and control outputs
// R3 - Request/grant lines are bidirectional active low
// R4 - Lock output low keeps other masters off
// R5 - Maximum mode reports instruction queue status
// R6 - Memory/IO select high for memory cycles
// R7 - Write strobe low while write data shown
// R8 - Interrupt acknowledge strobe reads acknowledge cycles
// R9 - Address latch pulse in T1, never floats
// R10 - Transceiver direction high transmit, low receive
// R11 - Transceiver enable low, floats during hold
// R12 - Hold request answered by hold grant
// R13 - Fully static state, clock may stop
// R14 - Prefetch up to six bytes ahead; code keeps up to six in the queue plus two in the buffer, eight in all
// R15 - Segment times sixteen plus offset address
// R16 - Byte lanes by address; odd words split
// R17 - Vector pointers are four bytes each
// R18 - Automatic segment choice with override
// R19 - Mode pin selects strobes or status
// R20 - External latch needed for demultiplexed address
// R21 - Address in T1, data afterwards
// R22 - Strobes active from T2 until T4
// R23 - Fetching starts at FFFF0 after reset
// R24 - Request, grant, release as one-clock pulses
`timescale 1ns/1ps
`default_nettype none
module bus_unit
  import bus_unit_pkg::*;
#(
  parameter int QD = QUEUE_DEPTH
) (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic mode_select_pin_i,
  input wire logic hold_req_i,
  input wire logic ready_i,
  input wire logic [15:0] ad_i,
  input wire logic bus_req_grant_line0_i,
  input wire logic bus_req_grant_line1_i,
  input wire logic req_valid_i,
  input wire logic [2:0] req_kind_i,
  input wire logic [15:0] req_offset_i,
  input wire logic req_word_i,
  input wire logic [15:0] req_wdata_i,
  input wire logic req_lock_i,
  input wire logic req_stack_i,
  input wire logic req_bp_i,
  input wire logic req_str_dst_i,
  input wire logic req_ovr_en_i,
  input wire logic [1:0] req_ovr_seg_i,
  input wire logic [15:0] data_seg_i,
  input wire logic [15:0] stack_seg_i,
  input wire logic [15:0] extra_seg_i,
  input wire logic flush_i,
  input wire logic [15:0] flush_cs_i,
  input wire logic [15:0] flush_ip_i,
  input wire logic q_ready_i,
  input wire logic q_first_i,
  output logic req_ready_o,
  output logic rsp_valid_o,
  output logic [15:0] rsp_data_o,
  output logic q_valid_o,
  output logic [7:0] q_byte_o,
  output logic [15:0] ad_o,
  output logic ad_oe_o,
  output logic [3:0] addr_hi_o,
  output logic high_byte_enable_n_o,
  output logic addr_hi_oe_o,
  output logic [2:0] bus_status_o,
  output logic ctl_oe_o,
  output logic lock_n_o,
  output logic [1:0] queue_state_pair_o,
  output logic mem_io_o,
  output logic read_strobe_n_o,
  output logic write_strobe_n_o,
  output logic irq_ack_strobe_n_o,
  output logic addr_latch_o,
  output logic xcvr_direction_o,
  output logic xcvr_enable_n_o,
  output logic hold_grant_o,
  output logic bus_req_grant_line0_o,
  output logic bus_req_grant_line0_oe_o,
  output logic bus_req_grant_line1_o,
  output logic bus_req_grant_line1_oe_o
);

  localparam int QCW = $clog2(QD + 1);

  typedef struct packed {
    bus_state_t st;
    logic [3:0] seq_cnt;
    logic rst_done;
    logic mode_s1, mode_s2, hold_s1, hold_s2, rdy_s1, rdy_s2;
    logic rg0_s1, rg0_s2, rg0_prev, rg1_s1, rg1_s2, rg1_prev;
    logic [15:0] ad_s1, ad_s2;
    logic [15:0] cs, ip;
    logic [QD-1:0][7:0] qmem;
    logic [QCW-1:0] qcnt;
    logic [1:0][7:0] buff;
    logic [1:0] bcnt;
    logic pend, p_word, p_lock, p_split;
    logic [2:0] p_kind;
    logic [1:0] p_seg;
    logic [19:0] p_addr;
    logic [15:0] p_wdata;
    logic [7:0] p_lo;
    logic cyc_fetch, cyc_drop, cyc_bhe_n;
    logic [2:0] cyc_kind;
    logic [1:0] cyc_seg;
    logic [19:0] cyc_addr;
    logic [1:0] cap_pipe;
    logic rg_line;
    logic [1:0] rg_ign;
    logic rg0_req, rg1_req;
    logic rr, rsp_valid, qv;
    logic [15:0] rsp_data, ad;
    logic ad_oe, ahi_oe, bhe_n, ctl_oe, lock_n, mio;
    logic [3:0] ahi;
    logic [2:0] bus_status;
    logic [1:0] qs;
    logic rd_n, wr_n, irq_ack_strobe_n_n, ale, dtr, den_n, hold_grant, rg0_oe, rg1_oe;
  } state_t;

  state_t s_r;
  state_t s_nxt;

  function automatic logic [1:0] seg_select(input logic stk, input logic bp, input logic dst,
                                            input logic ovr, input logic [1:0] oseg);
    if (dst) begin
      seg_select = SEG_EXTRA;
    end else if (ovr) begin
      seg_select = oseg;
    end else if (stk || bp) begin
      seg_select = SEG_STACK;
    end else begin
      seg_select = SEG_DATA;
    end
  endfunction : seg_select

  always_comb begin
    logic minm;
    logic locked;
    logic rg0_fall;
    logic rg1_fall;
    logic bus;
    logic sp;
    logic [7:0] rbyte;
    logic [15:0] base;
    logic [1:0] sel;
    minm = s_r.mode_s2;
    locked = s_r.pend && s_r.p_lock;
    rg0_fall = s_r.rg0_prev && !s_r.rg0_s2;
    rg1_fall = s_r.rg1_prev && !s_r.rg1_s2;
    rbyte = s_r.cyc_addr[0] ? s_r.ad_s2[15:8] : s_r.ad_s2[7:0];
    base = data_seg_i;
    sel = SEG_DATA;
    s_nxt = s_r;
    s_nxt.mode_s1 = mode_select_pin_i;
    s_nxt.mode_s2 = s_r.mode_s1;
    s_nxt.hold_s1 = hold_req_i;
    s_nxt.hold_s2 = s_r.hold_s1;
    s_nxt.rdy_s1 = ready_i;
    s_nxt.rdy_s2 = s_r.rdy_s1;
    s_nxt.rg0_s1 = bus_req_grant_line0_i;
    s_nxt.rg0_s2 = s_r.rg0_s1;
    s_nxt.rg0_prev = s_r.rg0_s2;
    s_nxt.rg1_s1 = bus_req_grant_line1_i;
    s_nxt.rg1_s2 = s_r.rg1_s1;
    s_nxt.rg1_prev = s_r.rg1_s2;
    s_nxt.ad_s1 = ad_i;
    s_nxt.ad_s2 = s_r.ad_s1;
    s_nxt.rsp_valid = 1'b0;
    s_nxt.rg0_oe = 1'b0;
    s_nxt.rg1_oe = 1'b0;
    s_nxt.qs = QS_NOP;
    s_nxt.cap_pipe = {s_r.cap_pipe[0], 1'b0};
    // A request pulse that lands during a bus cycle waits here until the bus is idle.
    if (!minm && s_r.st != BS_HOLD) begin
      s_nxt.rg0_req = s_r.rg0_req || rg0_fall; // R3
      s_nxt.rg1_req = s_r.rg1_req || rg1_fall;
    end

    // The internal start-up sequence runs before the first code fetch.
    if (!s_r.rst_done) begin
      s_nxt.seq_cnt = s_r.seq_cnt + 4'h1;
      s_nxt.rst_done = (s_r.seq_cnt == 4'(RESET_SEQ_CYCLES - 1)); // R23
    end

    // The execution unit drains the two-entry buffer; the queue refills it.
    if (s_r.qv && q_ready_i) begin
      s_nxt.buff[0] = s_r.buff[1];
      s_nxt.bcnt = s_r.bcnt - 2'h1;
      s_nxt.qs = q_first_i ? QS_FIRST : QS_NEXT; // R5
    end
    if (s_nxt.bcnt != 2'h2 && s_nxt.qcnt != '0) begin
      s_nxt.buff[s_nxt.bcnt[0]] = s_nxt.qmem[0]; // R14
      s_nxt.bcnt = s_nxt.bcnt + 2'h1;
      for (int i = 0; i < QD - 1; i++) begin
        s_nxt.qmem[i] = s_nxt.qmem[i+1];
      end
      s_nxt.qcnt = s_nxt.qcnt - QCW'(1);
    end

    if (req_valid_i && s_r.rr) begin
      sel = seg_select(req_stack_i, req_bp_i, req_str_dst_i, req_ovr_en_i, req_ovr_seg_i); // R18
      case (sel)
        SEG_EXTRA: base = extra_seg_i;
        SEG_STACK: base = stack_seg_i;
        SEG_CODE: base = s_r.cs;
        default: base = data_seg_i;
      endcase
      s_nxt.pend = 1'b1;
      s_nxt.p_kind = req_kind_i;
      s_nxt.p_word = req_word_i;
      s_nxt.p_wdata = req_wdata_i;
      s_nxt.p_lock = req_lock_i;
      s_nxt.p_split = 1'b0;
      if (req_kind_i == ST_IO_RD || req_kind_i == ST_IO_WR) begin
        s_nxt.p_addr = {4'h0, req_offset_i};
        s_nxt.p_seg = SEG_CODE;
      end else if (req_kind_i == ST_IRQ_ACK_STROBE_N || req_kind_i == ST_HALT) begin
        s_nxt.p_addr = 20'h00000;
        s_nxt.p_seg = SEG_CODE;
      end else begin
        s_nxt.p_addr = phys_addr(base, req_offset_i); // R15
        s_nxt.p_seg = sel;
      end
    end

    // A locked request taken this cycle must already keep hold and grants off.
    locked = s_nxt.pend && s_nxt.p_lock; // R4

    // Pin data sampled at the edge ending T4 appears here two cycles later.
    if (s_r.cap_pipe[1]) begin
      if (s_r.cyc_fetch) begin
        if (!s_r.cyc_drop) begin
          s_nxt.qmem[s_nxt.qcnt] = rbyte;
          s_nxt.qcnt = s_nxt.qcnt + QCW'(1);
          if (!s_r.cyc_addr[0]) begin
            s_nxt.qmem[s_nxt.qcnt] = s_r.ad_s2[15:8];
            s_nxt.qcnt = s_nxt.qcnt + QCW'(1);
          end
          s_nxt.ip = s_r.ip + (s_r.cyc_addr[0] ? 16'h0001 : 16'h0002);
        end
      end else if (s_r.p_word && s_r.p_addr[0]) begin
        s_nxt.p_lo = rbyte; // R16
        s_nxt.p_split = 1'b1;
        s_nxt.p_word = 1'b0;
        s_nxt.p_addr = s_r.p_addr + 20'h00001;
        s_nxt.p_wdata = {8'h00, s_r.p_wdata[15:8]};
      end else begin
        s_nxt.pend = 1'b0;
        s_nxt.rsp_valid = 1'b1;
        if (s_r.p_kind == ST_IRQ_ACK_STROBE_N) begin
          s_nxt.rsp_data = {6'h00, s_r.ad_s2[7:0], 2'b00}; // R17
        end else if (s_r.p_split) begin
          s_nxt.rsp_data = {rbyte, s_r.p_lo};
        end else if (s_r.p_word) begin
          s_nxt.rsp_data = s_r.ad_s2;
        end else begin
          s_nxt.rsp_data = {8'h00, rbyte};
        end
      end
    end

    case (s_r.st)
      BS_IDLE: begin
        if (s_r.cap_pipe == 2'b00) begin
          if (minm && s_r.hold_s2 && !locked) begin
            s_nxt.st = BS_HOLD; // R12
          end else if (!minm && (s_r.rg0_req || s_r.rg1_req) && !locked) begin
            s_nxt.st = BS_HOLD; // R24
            s_nxt.rg_line = !s_r.rg0_req;
            s_nxt.rg0_oe = s_r.rg0_req; // R3
            s_nxt.rg1_oe = !s_r.rg0_req;
            s_nxt.rg0_req = 1'b0;
            s_nxt.rg1_req = s_r.rg0_req && s_r.rg1_req;
            s_nxt.rg_ign = RG_ECHO_IGNORE;
          end else if (s_r.pend) begin
            s_nxt.st = BS_T1;
            s_nxt.cyc_fetch = 1'b0;
            s_nxt.cyc_kind = s_r.p_kind;
            s_nxt.cyc_addr = s_r.p_addr;
            s_nxt.cyc_seg = s_r.p_seg;
            s_nxt.cyc_bhe_n = !(s_r.p_addr[0] || s_r.p_word); // R16
          end else if (s_r.rst_done && !flush_i && s_nxt.qcnt <= QCW'(QD - 2)) begin
            s_nxt.st = BS_T1; // R14
            s_nxt.cyc_fetch = 1'b1;
            s_nxt.cyc_drop = 1'b0;
            s_nxt.cyc_kind = ST_FETCH;
            s_nxt.cyc_addr = phys_addr(s_r.cs, s_r.ip); // R23
            s_nxt.cyc_seg = SEG_CODE; // R18
            s_nxt.cyc_bhe_n = 1'b0;
          end
        end
      end
      BS_T1: s_nxt.st = BS_T2;
      BS_T2: s_nxt.st = BS_T3;
      BS_T3, BS_TW: s_nxt.st = s_r.rdy_s2 ? BS_T4 : BS_TW;
      BS_T4: begin
        s_nxt.st = BS_IDLE;
        s_nxt.cap_pipe = 2'b01;
      end
      BS_HOLD: begin
        if (minm) begin
          if (!s_r.hold_s2) begin
            s_nxt.st = BS_IDLE; // R12
          end
        end else if (s_r.rg_ign != 2'h0) begin
          s_nxt.rg_ign = s_r.rg_ign - 2'h1;
        end else if (s_r.rg_line ? rg1_fall : rg0_fall) begin
          s_nxt.st = BS_IDLE; // R24
        end
      end
      default: s_nxt.st = BS_IDLE;
    endcase

    // A jump discards queued bytes and any fetch still in flight.
    if (flush_i) begin
      s_nxt.cs = flush_cs_i;
      s_nxt.ip = flush_ip_i;
      s_nxt.qcnt = '0;
      s_nxt.bcnt = 2'h0;
      s_nxt.qs = QS_EMPTY; // R5
      s_nxt.cyc_drop = s_nxt.cyc_fetch;
    end

    // Pin values for the coming cycle, so every output is a flop.
    bus = s_nxt.st != BS_IDLE && s_nxt.st != BS_HOLD;
    sp = s_nxt.st == BS_T2 || s_nxt.st == BS_T3 || s_nxt.st == BS_TW;
    s_nxt.bus_status = (!minm && bus && s_nxt.st != BS_T4) ? s_nxt.cyc_kind
                                                          : ST_PASSIVE; // R1 R19
    if (minm) begin
      s_nxt.qs = QS_NOP; // R19
    end
    s_nxt.ale = minm && s_nxt.st == BS_T1; // R9 R20
    s_nxt.rd_n = !(sp && is_read(s_nxt.cyc_kind)); // R22
    s_nxt.wr_n = !(minm && sp && is_write(s_nxt.cyc_kind)); // R7 R22
    s_nxt.irq_ack_strobe_n_n = !(minm && sp && s_nxt.cyc_kind == ST_IRQ_ACK_STROBE_N); // R8 R22
    s_nxt.den_n = !(minm && (sp || (s_nxt.st == BS_T4
                                    && is_write(s_nxt.cyc_kind)))); // R11
    s_nxt.dtr = bus ? is_write(s_nxt.cyc_kind) : 1'b1; // R10
    s_nxt.mio = s_nxt.cyc_kind[2]; // R6
    s_nxt.lock_n = !(!minm && s_nxt.pend && s_nxt.p_lock); // R4
    s_nxt.ctl_oe = s_nxt.st != BS_HOLD; // R2 R11
    s_nxt.ahi_oe = s_nxt.st != BS_HOLD;
    s_nxt.hold_grant = minm && s_nxt.st == BS_HOLD; // R12
    s_nxt.ad_oe = s_nxt.st == BS_T1 || (bus && is_write(s_nxt.cyc_kind)); // R21
    if (s_nxt.st == BS_T1) begin
      s_nxt.ad = s_nxt.cyc_addr[15:0]; // R21
      s_nxt.ahi = s_nxt.cyc_addr[19:16];
      s_nxt.bhe_n = s_nxt.cyc_bhe_n; // R16
    end else begin
      s_nxt.ad = (s_nxt.p_word && !s_nxt.cyc_addr[0]) ? s_nxt.p_wdata
                 : {s_nxt.p_wdata[7:0], s_nxt.p_wdata[7:0]};
      s_nxt.ahi = {2'b00, s_nxt.cyc_seg};
      s_nxt.bhe_n = 1'b0;
    end
    s_nxt.rr = !s_nxt.pend && s_nxt.rst_done;
    s_nxt.qv = s_nxt.bcnt != 2'h0;
  end

  // Everything lives in flip-flops with no refresh, so a stopped clock only
  // freezes the unit; nothing here counts wall-clock time.
  always_ff @(posedge clock_i or negedge resetn_i) begin // R13
    if (!resetn_i) begin
      s_r <= '0;
      s_r.cs <= RESET_CODE_SEG;
      s_r.ip <= RESET_IP;
      s_r.st <= BS_IDLE;
      s_r.bus_status <= ST_PASSIVE;
      s_r.rg0_s1 <= 1'b1;
      s_r.rg0_s2 <= 1'b1;
      s_r.rg0_prev <= 1'b1;
      s_r.rg1_s1 <= 1'b1;
      s_r.rg1_s2 <= 1'b1;
      s_r.rg1_prev <= 1'b1;
      s_r.rd_n <= 1'b1;
      s_r.wr_n <= 1'b1;
      s_r.irq_ack_strobe_n_n <= 1'b1;
      s_r.den_n <= 1'b1;
      s_r.lock_n <= 1'b1;
      s_r.dtr <= 1'b1;
      s_r.bhe_n <= 1'b1;
      s_r.ctl_oe <= 1'b1;
      s_r.ahi_oe <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign req_ready_o = s_r.rr;
  assign rsp_valid_o = s_r.rsp_valid;
  assign rsp_data_o = s_r.rsp_data;
  assign q_valid_o = s_r.qv;
  assign q_byte_o = s_r.buff[0];
  assign ad_o = s_r.ad;
  assign ad_oe_o = s_r.ad_oe;
  assign addr_hi_o = s_r.ahi;
  assign high_byte_enable_n_o = s_r.bhe_n;
  assign addr_hi_oe_o = s_r.ahi_oe;
  assign bus_status_o = s_r.bus_status;
  assign ctl_oe_o = s_r.ctl_oe;
  assign lock_n_o = s_r.lock_n;
  assign queue_state_pair_o = s_r.qs;
  assign mem_io_o = s_r.mio;
  assign read_strobe_n_o = s_r.rd_n;
  assign write_strobe_n_o = s_r.wr_n;
  assign irq_ack_strobe_n_o = s_r.irq_ack_strobe_n_n;
  assign addr_latch_o = s_r.ale;
  assign xcvr_direction_o = s_r.dtr;
  assign xcvr_enable_n_o = s_r.den_n;
  assign hold_grant_o = s_r.hold_grant;
  // Grant pulses only ever pull the line low; release is by the enable.
  assign bus_req_grant_line0_o = 1'b0;
  assign bus_req_grant_line0_oe_o = s_r.rg0_oe;
  assign bus_req_grant_line1_o = 1'b0;
  assign bus_req_grant_line1_oe_o = s_r.rg1_oe;

endmodule : bus_unit
`default_nettype wire

//--- bus_unit_asserts.sv
// Checker on the bus unit ports: strobes, hold, grant and queue status.
// Assumes one clock domain; attached to every bus_unit by the bind below.
`timescale 1ns/1ps
`default_nettype none
module bus_unit_asserts
  import bus_unit_pkg::*;
(
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic mode_select_pin_i,
  input wire logic hold_req_i,
  input wire logic flush_i,
  input wire logic q_ready_i,
  input wire logic q_first_i,
  input wire logic q_valid_o,
  input wire logic ad_oe_o,
  input wire logic ctl_oe_o,
  input wire logic addr_hi_oe_o,
  input wire logic lock_n_o,
  input wire logic [2:0] bus_status_o,
  input wire logic irq_ack_strobe_n_o,
  input wire logic [1:0] queue_state_pair_o,
  input wire logic read_strobe_n_o,
  input wire logic write_strobe_n_o,
  input wire logic xcvr_direction_o,
  input wire logic xcvr_enable_n_o,
  input wire logic addr_latch_o,
  input wire logic hold_grant_o,
  input wire logic bus_req_grant_line0_o,
  input wire logic bus_req_grant_line0_oe_o
);
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!resetn_i);
  a_hold_floats: assert property (
    hold_grant_o |-> !ctl_oe_o && !ad_oe_o && !addr_hi_oe_o) else $error("driven in hold");
  a_ale_pulse: assert property (
    addr_latch_o |-> ad_oe_o && ctl_oe_o ##1 !addr_latch_o) else $error("bad latch pulse");
  a_write_drive: assert property (
    !write_strobe_n_o && ctl_oe_o |-> ad_oe_o && xcvr_direction_o && !xcvr_enable_n_o)
    else $error("bad write phase");
  a_read_turn: assert property (
    mode_select_pin_i && !read_strobe_n_o && ctl_oe_o |->
    !ad_oe_o && !xcvr_direction_o && !xcvr_enable_n_o) else $error("bad read phase");
  a_strobe_width: assert property (
    $fell(read_strobe_n_o) |=> !read_strobe_n_o) else $error("read strobe too short");
  a_grant_pulse: assert property (
    bus_req_grant_line0_oe_o |-> !bus_req_grant_line0_o ##1 !bus_req_grant_line0_oe_o)
    else $error("bad grant pulse");
  a_hold_answer: assert property (
    $rose(hold_req_i) && mode_select_pin_i && lock_n_o |-> ##[1:80] hold_grant_o)
    else $error("hold not granted");
  a_lock_blocks: assert property (
    !lock_n_o && ctl_oe_o |-> !hold_grant_o && !bus_req_grant_line0_oe_o)
    else $error("bus given away under lock");
  a_flush_status: assert property (
    flush_i && !q_ready_i && !mode_select_pin_i |=> queue_state_pair_o == QS_EMPTY)
    else $error("flush not reported");
  a_take_status: assert property (
    q_valid_o && q_ready_i && !flush_i && !mode_select_pin_i |=>
    queue_state_pair_o == ($past(q_first_i) ? QS_FIRST : QS_NEXT)) else $error("take not reported");
  a_status_read: assert property (
    !mode_select_pin_i && !read_strobe_n_o |-> is_read(bus_status_o))
    else $error("bad read status");
  a_irq_ack_strobe_n_strobe: assert property (
    !irq_ack_strobe_n_o |-> mode_select_pin_i && read_strobe_n_o && !ad_oe_o)
    else $error("bad acknowledge strobe");
  c_hold: cover property (hold_grant_o);
  c_lock: cover property (!lock_n_o);
  c_grant: cover property (bus_req_grant_line0_oe_o);
  c_write: cover property ($fell(write_strobe_n_o));
  c_max_read: cover property ($fell(read_strobe_n_o) && !mode_select_pin_i);
endmodule : bus_unit_asserts
bind bus_unit bus_unit_asserts i_chk (.*);
`default_nettype wire

//--- bus_unit_mem.sv
// Memory and I/O model on the shared address/data lines, with optional wait states.
// Assumes the device drives ad_o only while ad_oe_o is high.
`timescale 1ns/1ps
`default_nettype none
module bus_unit_mem (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic slow_i,
  input wire logic [15:0] ad_o,
  input wire logic ad_oe_o,
  input wire logic [3:0] addr_hi_o,
  input wire logic read_strobe_n_o,
  output logic [15:0] ad_pin_o,
  output logic ready_o
);
  logic [19:0] addr_r;
  logic [15:0] last_r;
  logic [2:0] wait_r;
  logic [1:0] keep_r;
  logic oe_r;
  function automatic logic [7:0] pat(input logic [19:0] a);
    pat = a[7:0] ^ a[15:8] ^ {a[19:16], a[19:16]};
  endfunction : pat
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      addr_r <= 20'h0;
      last_r <= 16'h0;
      wait_r <= 3'h0;
      keep_r <= 2'h0;
      oe_r <= 1'b0;
    end else begin
      oe_r <= ad_oe_o;
      if (ad_oe_o && !oe_r) begin
        addr_r <= {addr_hi_o, ad_o};
        wait_r <= slow_i ? 3'h4 : 3'h0;
      end else if (wait_r != 3'h0) begin
        wait_r <= wait_r - 3'h1;
      end
      keep_r <= !read_strobe_n_o ? 2'h3 : keep_r - {1'b0, keep_r != 2'h0};
      last_r <= ad_pin_o;
    end
  end
  // Ready drops already in T1, so the device's two-flop sampling still inserts waits.
  assign ready_o = wait_r == 3'h0 && !(slow_i && ad_oe_o && !oe_r);
  // Released lines show the inverse of the last level, so stale data never matches.
  always_comb begin
    if (ad_oe_o) begin
      ad_pin_o = ad_o;
    end else if (!read_strobe_n_o || keep_r != 2'h0) begin
      ad_pin_o = {pat(addr_r | 20'h1), pat(addr_r & ~20'h1)};
    end else begin
      ad_pin_o = ~last_r;
    end
  end
endmodule : bus_unit_mem
`default_nettype wire

//--- bus_unit_tb.sv
// Self-checking bench for the bus unit with a memory model on the shared lines.
// Assumes bus_unit_mem answers every read and the checker is bound to the design.
`timescale 1ns/1ps
`default_nettype none
module bus_unit_tb;
  import bus_unit_pkg::*;
  logic clock_i = 1'b0;
  logic resetn_i = 1'b0;
  logic mode = 1'b1, hreq = 1'b0, slow = 1'b0, rv = 1'b0, rw = 1'b0, rlock = 1'b0;
  logic stk = 1'b0, bp = 1'b0, strd = 1'b0, ovr = 1'b0, flush = 1'b0, qrdy = 1'b0;
  logic qfirst = 1'b0, q_en = 1'b1;
  logic [1:0] oseg = 2'h0, rg_drv = 2'h3;
  logic [2:0] kind = 3'h5;
  logic [15:0] off = 16'h0, wdata = 16'h0, dseg = 16'h0, sseg = 16'h0, eseg = 16'h0;
  logic [15:0] fcs = 16'h0, fip = 16'h0, cs = RESET_CODE_SEG;
  logic [19:0] faddr = {RESET_CODE_SEG, 4'h0} + {4'h0, RESET_IP};
  logic [16:0] expq[$];
  logic [16:0] e;
  logic [2:0] kinds[6] = '{ST_IRQ_ACK_STROBE_N, ST_IO_RD, ST_IO_WR, ST_HALT, ST_MEM_RD, ST_MEM_WR};
  wire logic [15:0] ad_pin, ad_out, rdata;
  wire logic [3:0] ahi;
  wire logic [7:0] qbyte;
  wire logic ad_oe, rd_n, wr_n, mio, rsp_v, rdy, q_v, hld, ctl_oe, ready, oe0, oe1, g0, g1;
  int fails = 0, n_checks = 0, cycles = 0, seed = 32'h3cb81a30;
  bus_unit i_dut (
    .clock_i(clock_i), .resetn_i(resetn_i), .mode_select_pin_i(mode), .hold_req_i(hreq),
    .ready_i(ready), .ad_i(ad_pin), .bus_req_grant_line0_i(oe0 ? g0 : rg_drv[0]),
    .bus_req_grant_line1_i(oe1 ? g1 : rg_drv[1]), .req_valid_i(rv), .req_kind_i(kind),
    .req_offset_i(off), .req_word_i(rw), .req_wdata_i(wdata), .req_lock_i(rlock),
    .req_stack_i(stk), .req_bp_i(bp), .req_str_dst_i(strd), .req_ovr_en_i(ovr),
    .req_ovr_seg_i(oseg), .data_seg_i(dseg), .stack_seg_i(sseg), .extra_seg_i(eseg),
    .flush_i(flush), .flush_cs_i(fcs), .flush_ip_i(fip), .q_ready_i(qrdy), .q_first_i(qfirst),
    .req_ready_o(rdy), .rsp_valid_o(rsp_v), .rsp_data_o(rdata), .q_valid_o(q_v),
    .q_byte_o(qbyte), .ad_o(ad_out), .ad_oe_o(ad_oe), .addr_hi_o(ahi),
    .high_byte_enable_n_o(), .addr_hi_oe_o(), .bus_status_o(), .ctl_oe_o(ctl_oe),
    .lock_n_o(), .queue_state_pair_o(), .mem_io_o(mio), .read_strobe_n_o(rd_n),
    .write_strobe_n_o(wr_n), .irq_ack_strobe_n_o(), .addr_latch_o(), .xcvr_direction_o(),
    .xcvr_enable_n_o(), .hold_grant_o(hld), .bus_req_grant_line0_o(g0),
    .bus_req_grant_line0_oe_o(oe0), .bus_req_grant_line1_o(g1), .bus_req_grant_line1_oe_o(oe1)
  );
  bus_unit_mem i_mem (.clock_i(clock_i), .resetn_i(resetn_i), .slow_i(slow), .ad_o(ad_out),
    .ad_oe_o(ad_oe), .addr_hi_o(ahi), .read_strobe_n_o(rd_n), .ad_pin_o(ad_pin), .ready_o(ready));
  initial begin
    forever #50 clock_i = ~clock_i;
  end
  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      $display("unexpected %s expected %h seen %h", name, exp, got);
      fails++;
    end
  endtask : check
  task automatic results();
    if (fails == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : results
  function automatic logic [19:0] addr_of(input logic [15:0] o);
    logic [15:0] s;
    s = strd ? eseg : !ovr ? ((stk || bp) ? sseg : dseg) : oseg == SEG_EXTRA ? eseg :
      oseg == SEG_STACK ? sseg : oseg == SEG_CODE ? cs : dseg;
    addr_of = kind[2] ? {s, 4'h0} + {4'h0, o} : {4'h0, o};
  endfunction : addr_of
  task automatic do_req(input logic [2:0] k, input logic w, input logic h);
    logic [19:0] a;
    int n;
    n = 0;
    while (rdy !== 1'b1 && n < 400) begin
      @(negedge clock_i);
      n++;
    end
    kind = k;
    rw = w;
    rlock = h;
    {off, wdata} = $random(seed);
    {dseg, sseg} = $random(seed);
    {eseg, stk, bp, strd, ovr, oseg, slow} = 23'($random(seed));
    off[15] = 1'b0;
    a = addr_of(off);
    expq.push_back({k == ST_MEM_RD || k == ST_IO_RD,
                    w ? {i_mem.pat(a + 20'h1), i_mem.pat(a)} : {8'h00, i_mem.pat(a)}});
    rv = 1'b1;
    @(negedge clock_i);
    rv = 1'b0;
    hreq = h;
    n = 0;
    while (rsp_v !== 1'b1 && n < 400) begin
      @(negedge clock_i);
      n++;
    end
    @(negedge clock_i);
    rlock = 1'b0;
  endtask : do_req
  task automatic do_flush(input logic [15:0] c, input logic [15:0] p);
    q_en = 1'b0;
    repeat (2) @(negedge clock_i);
    {flush, fcs, fip, cs} = {1'b1, c, p, c};
    @(negedge clock_i);
    flush = 1'b0;
    repeat (2) @(negedge clock_i);
    q_en = 1'b1;
  endtask : do_flush
  task automatic do_grant(input int i);
    int n;
    rg_drv[i] = 1'b0;
    @(negedge clock_i);
    rg_drv[i] = 1'b1;
    n = 0;
    while ((i == 0 ? oe0 : oe1) !== 1'b1 && n < 100) begin
      @(negedge clock_i);
      n++;
    end
    check("grant_oe", 16'h1, {15'h0, i == 0 ? oe0 : oe1});
    repeat (6) @(negedge clock_i);
    check("ctl_oe", 16'h0, {15'h0, ctl_oe});
    rg_drv[i] = 1'b0;
    @(negedge clock_i);
    rg_drv[i] = 1'b1;
    repeat (8) @(negedge clock_i);
    check("ctl_oe", 16'h1, {15'h0, ctl_oe});
  endtask : do_grant
  always @(negedge clock_i) begin
    qrdy <= q_en && 1'($random(seed));
    qfirst <= 1'($random(seed));
  end
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 30000) begin
      fails++;
      results();
    end
    if (rsp_v === 1'b1 && expq.size() > 0) begin
      e = expq.pop_front();
      if (e[16]) check("rsp_data", e[15:0], rdata);
    end
    if (q_v === 1'b1 && qrdy === 1'b1) begin
      check("q_byte", {8'h0, i_mem.pat(faddr)}, {8'h0, qbyte});
      faddr++;
    end
    if (flush === 1'b1) faddr = {fcs, 4'h0} + {4'h0, fip};
    if (wr_n === 1'b0 && ctl_oe === 1'b1) check("mem_io", {15'h0, kind[2]}, {15'h0, mio});
  end
  initial begin
    repeat (5) @(negedge clock_i);
    resetn_i = 1'b1;
    for (int j = 0; j < 36; j++) do_req(kinds[j % 6], 1'($random(seed)), 1'b0);
    do_flush(16'h1234, 16'h0100);
    do_req(ST_MEM_RD, 1'b1, 1'b1);
    while (hld !== 1'b1 && cycles < 29000) @(negedge clock_i);
    check("ctl_oe", 16'h0, {15'h0, ctl_oe});
    hreq = 1'b0;
    repeat (8) @(negedge clock_i);
    check("hold_grant", 16'h0, {15'h0, hld});
    q_en = 1'b0;
    repeat (60) @(negedge clock_i);
    mode = 1'b0;
    repeat (10) @(negedge clock_i);
    q_en = 1'b1;
    for (int j = 0; j < 6; j++) do_req(ST_MEM_RD, 1'b1, 1'b0);
    do_req(ST_MEM_RD, 1'b1, 1'b1);
    do_flush(16'h0abc, 16'h0020);
    do_grant(0);
    do_grant(1);
    do_req(ST_IO_RD, 1'b1, 1'b0);
    results();
  end
endmodule : bus_unit_tb
`default_nettype wire
